// File: src/sbhpe_defines.svh
// Constants of the serial bus host packet engine.
`ifndef SBHPE_DEFINES_SVH
`define SBHPE_DEFINES_SVH
`define SBHPE_SYNC_BYTE    8'h80
`define SBHPE_SYNC_BITS    4'h8
`define SBHPE_LOCK_BITS    4'h8
`define SBHPE_QUIET_END    4'h7
`define SBHPE_STUFF_RUN    3'h6
`define SBHPE_CRC_INIT     16'hFFFF
`define SBHPE_CRC_POLY     16'h8005
`define SBHPE_CRC_GOOD     16'h800D
`define SBHPE_PID_SOF      8'hA5
`define SBHPE_PID_ACK      8'hD2
`define SBHPE_PID_DATA     8'hC3
`define SBHPE_TOKEN_BYTES  2'h3
`define SBHPE_KIND_TOKEN   2'h0
`define SBHPE_KIND_HSHAKE  2'h1
`define SBHPE_KIND_OUT     2'h2
`define SBHPE_KIND_IN      2'h3
`define SBHPE_ST_IDLE      4'h0
`define SBHPE_ST_OK        4'h1
`define SBHPE_ST_TIMEOUT   4'h2
`define SBHPE_ST_CRC_ERR   4'h3
`define SBHPE_ST_NAK       4'h4
`define SBHPE_ST_BUSY      4'h8
`define SBHPE_TIMEOUT_W    16
`define SBHPE_DIV_W        8
`endif

// File: src/sbhpe_pkg.sv
// Types of the serial bus host packet engine.
package sbhpe_pkg;
   typedef enum logic [3:0]
   {
      SBHPE_IDLE  = 4'h0,
      SBHPE_FETCH = 4'h1,
      SBHPE_SYNC  = 4'h3,
      SBHPE_TOKEN = 4'h2,
      SBHPE_DATA  = 4'h6,
      SBHPE_CRC   = 4'h7,
      SBHPE_EOP   = 4'h5,
      SBHPE_WAIT  = 4'h4,
      SBHPE_RECV  = 4'hC,
      SBHPE_DONE  = 4'hD
   } sbhpe_state_t;
endpackage

// File: src/sbhpe_fifo.sv
// Parameterised FIFO with valid and ready on both sides and registered read data.
`timescale 1ns/1ns
`include "sbhpe_defines.svh"
module sbhpe_fifo
   import sbhpe_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
)
(
   // Clock and reset.
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic             ce,
   // Fill side.
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed
   {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic          ov;
      logic [WIDTH-1:0] od;
   } sbhpe_fifo_t;

   sbhpe_fifo_t r, next_r;
   logic [WIDTH-1:0] mem [DEPTH];
   logic wr;
   logic rd;
   logic [AW:0] stored;

   assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
   assign out_valid = r.ov;
   assign out_data  = r.od;
   assign wr = in_valid && in_ready;
   assign stored = r.cnt - (AW+1)'(r.ov);
   assign rd = (stored != '0) && (!r.ov || out_ready);

   always_comb
   begin
      next_r = r;
      if (wr)
      begin
         next_r.wp = (r.wp == AW'(DEPTH-1)) ? '0 : r.wp + 1'b1;
      end
      if (out_ready && r.ov)
      begin
         next_r.ov = 1'b0;
      end
      if (rd)
      begin
         next_r.rp = (r.rp == AW'(DEPTH-1)) ? '0 : r.rp + 1'b1;
         next_r.ov = 1'b1;
         next_r.od = mem[r.rp];
      end
      next_r.cnt = r.cnt + (AW+1)'(wr) - (AW+1)'(out_ready && r.ov);
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         r <= '0;
      end
      else if (ce)
      begin
         r <= next_r;
         if (wr)
         begin
            mem[r.wp] <= in_data;
         end
      end
   end
endmodule // sbhpe_fifo

// File: src/sbhpe_engine.sv
// Packet engine: token, data and handshake transfer with line coding, CRC, FIFO and time-out.
`timescale 1ns/1ns
`include "sbhpe_defines.svh"
module sbhpe_engine
   import sbhpe_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = 16'hFFFF,
   parameter int FIFO_DEPTH     = 4
)
(
   // Clock, reset and enable.
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        ce,
   // Transfer request from software.
   input  wire logic        req_write,
   input  wire logic [1:0]  req_kind,
   input  wire logic [7:0]  req_pid,
   input  wire logic [15:0] req_table_addr,
   input  wire logic        frame_start,
   input  wire logic [7:0]  rate_div,
   // Connection table read port.
   output logic             tbl_rd,
   output logic [15:0]      tbl_addr,
   input  wire logic [7:0]  tbl_data,
   // Host DMA side of the FIFO.
   input  wire logic        dma_tx_valid,
   output logic             dma_tx_ready,
   input  wire logic [7:0]  dma_tx_data,
   output logic             dma_rx_valid,
   input  wire logic        dma_rx_ready,
   output logic [7:0]       dma_rx_data,
   // Status.
   output logic [3:0]       status,
   output logic             busy,
   // Bus line.
   input  wire logic        line_in,
   output logic             line_out,
   output logic             line_oe
);
   typedef struct packed
   {
      sbhpe_state_t st;
      logic [1:0]   kind;
      logic         sof;
      logic [7:0]   pid;
      logic [15:0]  addr;
      logic [1:0]   nbyte;
      logic [7:0]   sh;
      logic [3:0]   nbit;
      logic [2:0]   ones;
      logic [15:0]  crc;
      logic [`SBHPE_TIMEOUT_W-1:0] tmo;
      logic [`SBHPE_DIV_W-1:0] div;
      logic [`SBHPE_DIV_W-1:0] dcnt;
      logic         lvl;
      logic         rlvl;
      logic         locked;
      logic [3:0]   lock_n;
      logic         in_sync;
      logic         rxd_go;
      logic [7:0]   rxb;
      logic         fifo_pop;
      logic         rd;
      logic [3:0]   status;
      logic         busy;
      logic         oe;
      logic         eprev;
      logic [3:0]   quiet;
      logic         rx_pay;
      logic [15:0]  crc_b;
   } sbhpe_r_t;

   sbhpe_r_t r, next_r;
   logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
   logic [7:0] f_in_data, f_out_data;
   logic tx_dir, tick, rx_bit, rx_stuff, tx_bit;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `SBHPE_CRC_POLY : 16'h0000);
   endfunction

   // Direction picks whether the FIFO is fed by DMA or by the receiver.
   assign tx_dir      = (r.kind == `SBHPE_KIND_OUT);
   assign f_in_valid  = tx_dir ? dma_tx_valid : r.rxd_go;
   assign f_in_data   = tx_dir ? dma_tx_data : r.rxb;
   assign f_out_ready = tx_dir ? r.fifo_pop : dma_rx_ready;
   assign dma_tx_ready = r.busy && tx_dir && f_in_ready;
   assign dma_rx_valid = !tx_dir && f_out_valid;
   assign dma_rx_data  = f_out_data;
   assign status   = r.status;
   assign busy     = r.busy;
   assign line_out = r.lvl;
   assign line_oe  = r.oe;
   assign tbl_rd   = r.rd;
   assign tbl_addr = r.addr;
   assign tick     = (r.dcnt == '0);
   assign tx_bit   = r.sh[0];
   assign rx_bit   = (line_in == r.rlvl);
   assign rx_stuff = (r.ones == `SBHPE_STUFF_RUN);

   sbhpe_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .mclk      (mclk),
      .resetn    (resetn),
      .ce        (ce),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (f_in_data),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   always_comb
   begin
      next_r = r;
      next_r.rd = 1'b0;
      next_r.fifo_pop = 1'b0;
      next_r.rxd_go = 1'b0;
      next_r.dcnt = tick ? r.div : r.dcnt - 1'b1;
      if (r.st == SBHPE_WAIT || r.st == SBHPE_RECV)
      begin
         next_r.tmo = r.tmo + 1'b1;
      end
      case (r.st)
         SBHPE_IDLE:
         begin
            next_r.oe = 1'b0;
            if (frame_start || req_write)
            begin
               next_r.sof  = frame_start;
               next_r.kind = frame_start ? `SBHPE_KIND_TOKEN : req_kind;
               next_r.pid  = frame_start ? `SBHPE_PID_SOF : req_pid;
               next_r.addr = req_table_addr;
               next_r.div  = rate_div;
               next_r.busy = 1'b1;
               next_r.status = `SBHPE_ST_BUSY;
               next_r.rd = 1'b1;
               next_r.st = SBHPE_FETCH;
            end
         end
         SBHPE_FETCH:
         begin
            next_r.sh = `SBHPE_SYNC_BYTE;
            // The line starts at the first sync level, so no stale level leaks out.
            next_r.lvl = 1'b0;
            next_r.nbit = '0;
            next_r.nbyte = '0;
            next_r.ones = '0;
            next_r.oe = 1'b1;
            next_r.dcnt = r.div;
            next_r.st = SBHPE_SYNC;
         end
         SBHPE_SYNC, SBHPE_TOKEN, SBHPE_DATA, SBHPE_CRC:
         begin
            if (tick)
            begin
               if (r.st == SBHPE_SYNC)
               begin
                  next_r.lvl = tx_bit;
                  next_r.sh = {1'b0, r.sh[7:1]};
                  next_r.nbit = r.nbit + 1'b1;
               end
               else if (r.ones == `SBHPE_STUFF_RUN)
               begin
                  next_r.lvl = !r.lvl;
                  next_r.ones = '0;
               end
               else
               begin
                  next_r.lvl = tx_bit ? r.lvl : !r.lvl;
                  next_r.ones = tx_bit ? r.ones + 1'b1 : '0;
                  next_r.sh = {1'b0, r.sh[7:1]};
                  next_r.nbit = r.nbit + 1'b1;
                  if (r.st != SBHPE_CRC)
                  begin
                     next_r.crc = crc_step(r.crc, tx_bit);
                  end
               end
               if (next_r.nbit == `SBHPE_SYNC_BITS)
               begin
                  next_r.nbit = '0;
                  next_r.nbyte = r.nbyte + 1'b1;
                  case (r.st)
                     SBHPE_SYNC:
                     begin
                        next_r.sh = r.pid;
                        next_r.crc = `SBHPE_CRC_INIT;
                        next_r.st = SBHPE_TOKEN;
                        next_r.nbyte = '0;
                        next_r.addr = r.addr + 1'b1;
                        next_r.rd = 1'b1;
                     end
                     SBHPE_TOKEN:
                     begin
                        if (r.pid == `SBHPE_PID_DATA)
                        begin
                           // A data packet carries its identifier, then the FIFO bytes.
                           next_r.crc = `SBHPE_CRC_INIT;
                           next_r.nbyte = '0;
                           next_r.st = f_out_valid ? SBHPE_DATA : SBHPE_CRC;
                           next_r.sh = f_out_valid ? f_out_data : ~next_r.crc[15:8];
                           next_r.fifo_pop = f_out_valid;
                        end
                        else
                        begin
                           next_r.sh = tbl_data;
                           next_r.addr = r.addr + 1'b1;
                           next_r.rd = 1'b1;
                           if (next_r.nbyte == `SBHPE_TOKEN_BYTES)
                           begin
                              next_r.sh = ~r.crc[15:8];
                              next_r.nbyte = '0;
                              next_r.st = SBHPE_CRC;
                           end
                        end
                     end
                     SBHPE_DATA:
                     begin
                        if (f_out_valid)
                        begin
                           next_r.sh = f_out_data;
                           next_r.fifo_pop = 1'b1;
                        end
                        else
                        begin
                           next_r.sh = ~r.crc[15:8];
                           next_r.nbyte = '0;
                           next_r.st = SBHPE_CRC;
                        end
                     end
                     default:
                     begin
                        next_r.sh = ~r.crc[7:0];
                        if (r.nbyte == 2'h1)
                        begin
                           next_r.st = SBHPE_EOP;
                        end
                     end
                  endcase
               end
            end
         end
         SBHPE_EOP:
         begin
            next_r.oe = 1'b0;
            next_r.tmo = '0;
            next_r.locked = 1'b0;
            next_r.lock_n = '0;
            next_r.in_sync = 1'b0;
            next_r.rlvl = line_in;
            next_r.crc = `SBHPE_CRC_INIT;
            if (r.kind == `SBHPE_KIND_TOKEN)
            begin
               next_r.st = SBHPE_DONE;
               next_r.status = `SBHPE_ST_OK;
            end
            else if (r.kind == `SBHPE_KIND_OUT && r.pid != `SBHPE_PID_DATA)
            begin
               // The data packet gets its own sync field after one idle cycle.
               next_r.pid = `SBHPE_PID_DATA;
               next_r.st = SBHPE_FETCH;
            end
            else
            begin
               next_r.st = SBHPE_WAIT;
            end
         end
         SBHPE_WAIT, SBHPE_RECV:
         begin
            next_r.eprev = line_in;
            if (r.st == SBHPE_WAIT && r.tmo == `SBHPE_TIMEOUT_W'(TIMEOUT_CYCLES))
            begin
               next_r.status = `SBHPE_ST_TIMEOUT;
               next_r.st = SBHPE_DONE;
            end
            else if (r.st == SBHPE_WAIT)
            begin
               // The sync field opens with a low level on the idle-high line.
               if (!line_in)
               begin
                  next_r.dcnt = {1'b0, r.div[`SBHPE_DIV_W-1:1]};
                  next_r.nbit = '0;
                  next_r.ones = '0;
                  next_r.quiet = '0;
                  next_r.rx_pay = 1'b0;
                  next_r.st = SBHPE_RECV;
               end
            end
            else if (line_in != r.eprev)
            begin
               next_r.dcnt = {1'b0, r.div[`SBHPE_DIV_W-1:1]};
               next_r.quiet = '0;
            end
            else if (tick)
            begin
               next_r.rlvl = line_in;
               next_r.quiet = r.quiet + 1'b1;
               if (!r.locked)
               begin
                  next_r.lock_n = r.lock_n + 1'b1;
                  next_r.locked = (next_r.lock_n == `SBHPE_LOCK_BITS);
                  next_r.in_sync = next_r.locked;
                  next_r.ones = '0;
               end
               else if (r.in_sync && r.quiet == `SBHPE_QUIET_END)
               begin
                  // Stuffing bounds a run without edges, so a longer one is the idle line.
                  next_r.status = (r.crc_b == `SBHPE_CRC_GOOD) ? `SBHPE_ST_OK : `SBHPE_ST_CRC_ERR;
                  next_r.st = SBHPE_DONE;
               end
               else if (rx_stuff)
               begin
                  next_r.ones = '0;
               end
               else
               begin
                  next_r.ones = rx_bit ? r.ones + 1'b1 : '0;
                  next_r.rxb = {rx_bit, r.rxb[7:1]};
                  next_r.nbit = r.nbit + 1'b1;
                  if (r.rx_pay)
                  begin
                     next_r.crc = crc_step(r.crc, rx_bit);
                  end
                  if (next_r.nbit == `SBHPE_SYNC_BITS)
                  begin
                     next_r.nbit = '0;
                     next_r.rx_pay = 1'b1;
                     next_r.crc_b = next_r.crc;
                     next_r.rxd_go = r.rx_pay && r.kind == `SBHPE_KIND_IN;
                     if (!r.rx_pay && r.kind != `SBHPE_KIND_IN)
                     begin
                        next_r.status = ({rx_bit, r.rxb[7:1]} == `SBHPE_PID_ACK) ? `SBHPE_ST_OK : `SBHPE_ST_NAK;
                        next_r.st = SBHPE_DONE;
                     end
                  end
               end
            end
         end
         SBHPE_DONE:
         begin
            next_r.busy = 1'b0;
            next_r.oe = 1'b0;
            next_r.st = SBHPE_IDLE;
         end
         default:
         begin
            next_r.st = SBHPE_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         r <= '0;
      end
      else if (ce)
      begin
         r <= next_r;
      end
   end
endmodule // sbhpe_engine

// File: bench/sbhpe_engine_monitor.sv
// Port checker of the packet engine.
`timescale 1ns/1ns
`include "sbhpe_defines.svh"
module sbhpe_engine_monitor
   import sbhpe_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = 16'hFFFF
)
(
   // Clock and control.
   input wire logic       mclk,
   input wire logic       resetn,
   input wire logic       ce,
   input wire logic       req_write,
   input wire logic       frame_start,
   input wire logic       tbl_rd,
   // Data paths.
   input wire logic       dma_tx_ready,
   input wire logic       dma_rx_valid,
   input wire logic       dma_rx_ready,
   input wire logic [7:0] dma_rx_data,
   // Status and line.
   input wire logic [3:0] status,
   input wire logic       busy,
   input wire logic       line_in,
   input wire logic       line_out,
   input wire logic       line_oe
);
   logic [15:0] wait_cnt;
   logic [15:0] quiet_cnt;
   logic        line_d;

   // Counts cycles spent waiting for the far side, and those without a line edge.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         wait_cnt  <= 16'h0000;
         quiet_cnt <= 16'h0000;
         line_d    <= 1'b1;
      end
      else
      begin
         wait_cnt  <= (busy && !line_oe) ? wait_cnt + 16'h0001 : 16'h0000;
         quiet_cnt <= (busy && !line_oe && line_in == line_d) ? quiet_cnt + 16'h0001 : 16'h0000;
         line_d    <= line_in;
      end
   end

   // ********
   // Assertions.
   // ********
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   AST_REQ_TAKEN: assert property (
      ce && !busy && (req_write || frame_start) |=>
      busy && status == `SBHPE_ST_BUSY && (tbl_rd || $past(frame_start)))
      else $error("request not taken");
   AST_OE_FOLLOWS: assert property (
      ce && $rose(busy) |=> line_oe)
      else $error("line not driven after start");
   AST_OE_IN_BUSY: assert property (
      line_oe |-> busy)
      else $error("line driven while idle");
   AST_SYNC_RAW: assert property (
      $rose(line_oe) |-> (line_oe && !line_out) [*7])
      else $error("sync field not raw zeros");
   AST_TX_READY_BUSY: assert property (
      dma_tx_ready |-> busy)
      else $error("fill side open while idle");
   AST_STATUS_HOLDS: assert property (
      !busy ##1 !busy |-> $stable(status))
      else $error("status changed while idle");
   AST_TIMEOUT_MIN: assert property (
      $rose(status == `SBHPE_ST_TIMEOUT) |-> wait_cnt + 16'h0001 >= 16'(TIMEOUT_CYCLES))
      else $error("time-out too early");
   AST_TIMEOUT_MAX: assert property (
      quiet_cnt <= 16'(TIMEOUT_CYCLES + 8))
      else $error("time-out missed");
   AST_RX_HOLD: assert property (
      dma_rx_valid && !dma_rx_ready |=> dma_rx_valid && $stable(dma_rx_data))
      else $error("drain side dropped a byte");
endmodule // sbhpe_engine_monitor

bind sbhpe_engine sbhpe_engine_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (.mclk, .resetn, .ce, .req_write,
   .frame_start, .tbl_rd, .dma_tx_ready, .dma_rx_valid, .dma_rx_ready, .dma_rx_data, .status, .busy, .line_in,
   .line_out, .line_oe);

// File: bench/sbhpe_peripheral.sv
// Peripheral model that answers the host on the shared bus line.
`timescale 1ns/1ns
`include "sbhpe_defines.svh"
module sbhpe_peripheral
   import sbhpe_pkg::*;
(
   // Clock and host line state.
   input wire logic       mclk,
   input wire logic       host_oe,
   // Answer: 0 silent, 1 handshake, 2 good data, 3 data with bad check code.
   input wire logic [1:0] mode,
   input wire logic [1:0] skip,
   input wire logic [7:0] gap_bits,
   input wire logic [7:0] bit_cycles,
   // Line drive.
   output logic           drv_oe,
   output logic           drv_out
);
   logic        lvl;
   logic        used;
   logic        prev_oe;
   logic [1:0]  seen;
   logic [2:0]  ones;
   logic [15:0] crc;

   task automatic hold(input logic v);
      drv_out <= v;
      lvl = v;
      repeat (bit_cycles) @(posedge mclk);
   endtask

   task automatic tx_bit(input logic b, input logic upd);
      if (upd)
         crc = {crc[14:0], 1'b0} ^ ((b ^ crc[15]) ? `SBHPE_CRC_POLY : 16'h0000);
      hold(b ? lvl : ~lvl);
      ones = b ? ones + 3'h1 : 3'h0;
      if (ones == `SBHPE_STUFF_RUN)
      begin
         hold(~lvl);
         ones = 3'h0;
      end
   endtask

   task automatic tx_byte(input logic [7:0] v, input logic upd);
      for (int i = 0; i < 8; i++)
         tx_bit(v[i], upd);
   endtask

   task automatic answer();
      logic [7:0]  sy;
      logic [15:0] fcs;
      sy = `SBHPE_SYNC_BYTE;
      repeat (gap_bits) repeat (bit_cycles) @(posedge mclk);
      drv_oe <= 1'b1;
      for (int i = 0; i < 8; i++)
         hold(sy[i]);
      ones = 3'h0;
      crc = `SBHPE_CRC_INIT;
      if (mode == 2'h1)
         tx_byte(`SBHPE_PID_ACK, 1'b0);
      else
      begin
         tx_byte(`SBHPE_PID_DATA, 1'b0);
         tx_byte(8'h3C, 1'b1);
         tx_byte(8'hFE, 1'b1);
         fcs = ~crc ^ {15'h0000, mode == 2'h3};
         for (int i = 15; i >= 0; i--)
            tx_bit(fcs[i], 1'b0);
      end
      drv_oe <= 1'b0;
   endtask

   // Answers once per armed transfer, after skipping the chosen number of host packets.
   initial
   begin
      drv_oe = 1'b0;
      drv_out = 1'b1;
      lvl = 1'b1;
      used = 1'b0;
      prev_oe = 1'b0;
      seen = 2'h0;
      forever
      begin
         @(posedge mclk);
         if (mode == 2'h0)
         begin
            used = 1'b0;
            seen = 2'h0;
         end
         else if (prev_oe && !host_oe && !used)
         begin
            if (seen == skip)
            begin
               used = 1'b1;
               answer();
            end
            else
               seen = seen + 2'h1;
         end
         prev_oe = host_oe;
      end
   end
endmodule // sbhpe_peripheral

// File: bench/sbhpe_engine_test.sv
// Self-checking test of the packet engine with a peripheral model on the line.
`timescale 1ns/1ns
`include "sbhpe_defines.svh"
module sbhpe_engine_test
   import sbhpe_pkg::*;
;
   localparam int TO   = 200;
   localparam int BITC = 4;

   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic        req_write = 1'b0;
   logic [1:0]  req_kind = 2'h0;
   logic [7:0]  req_pid = 8'h00;
   logic        frame_start = 1'b0;
   logic [7:0]  tbl_data = 8'h00;
   logic        dma_tx_valid = 1'b0;
   logic [7:0]  dma_tx_data = 8'h00;
   logic        dma_rx_ready = 1'b0;
   logic [1:0]  mode = 2'h0;
   logic [1:0]  skip = 2'h0;
   logic [7:0]  gap = 8'h02;
   logic        tbl_rd;
   logic [15:0] tbl_addr;
   logic        dma_tx_ready;
   logic        dma_rx_valid;
   logic [7:0]  dma_rx_data;
   logic [3:0]  status;
   logic        busy;
   logic        line_out;
   logic        line_oe;
   logic        p_oe;
   logic        p_out;
   wire logic   line;
   int          n_mismatch = 0;
   int          comparisons = 0;

   always #5 mclk = ~mclk;
   // The line has a pull-up, so it idles high when nobody drives it.
   assign line = line_oe ? line_out : (p_oe ? p_out : 1'b1);
   always_ff @(posedge mclk)
      if (tbl_rd)
         tbl_data <= tbl_addr[7:0] ^ 8'h5A;

   sbhpe_engine #(.TIMEOUT_CYCLES(TO), .FIFO_DEPTH(4)) uut (.mclk, .resetn, .ce(1'b1), .req_write, .req_kind,
      .req_pid, .req_table_addr(16'h0040), .frame_start, .rate_div(8'(BITC - 1)), .tbl_rd, .tbl_addr, .tbl_data,
      .dma_tx_valid, .dma_tx_ready, .dma_tx_data, .dma_rx_valid, .dma_rx_ready, .dma_rx_data, .status, .busy,
      .line_in(line), .line_out, .line_oe);
   sbhpe_peripheral peer (.mclk, .host_oe(line_oe), .mode, .skip, .gap_bits(gap), .bit_cycles(8'(BITC)),
      .drv_oe(p_oe), .drv_out(p_out));

   // ********
   // Checks and bus steps.
   // ********
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      chk_val({7'h00, got}, {7'h00, exp});
   endtask

   task automatic print_verdict();
      $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic start(input logic [1:0] kind, input logic [7:0] pid, input logic sof);
      @(posedge mclk);
      req_write <= 1'b1;
      frame_start <= sof;
      req_kind <= kind;
      req_pid <= pid;
      @(posedge mclk);
      req_write <= 1'b0;
      frame_start <= 1'b0;
      @(negedge mclk);
      chk_flag(busy, 1'b1);
      chk_val({4'h0, status}, {4'h0, `SBHPE_ST_BUSY});
   endtask

   task automatic finish_xfer(input logic [3:0] exp);
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 6000)
      begin
         @(negedge mclk);
         n++;
      end
      chk_flag(busy, 1'b0);
      chk_val({4'h0, status}, {4'h0, exp});
   endtask

   // Line levels of the sync field and the identifier byte, sampled mid-bit.
   task automatic grab(output logic [15:0] lv);
      int n;
      n = 0;
      while (line_oe !== 1'b1 && n < 100)
      begin
         @(negedge mclk);
         n++;
      end
      // The first sync bit follows one bit period of leading low level.
      repeat (BITC + 1) @(negedge mclk);
      for (int i = 0; i < 16; i++)
      begin
         lv[i] = line_out;
         repeat (BITC) @(negedge mclk);
      end
   endtask

   function automatic logic [7:0] pid_of(input logic [15:0] lv);
      logic [7:0] b;
      for (int i = 0; i < 8; i++)
         b[i] = lv[i + 8] ~^ lv[i + 7];
      return b;
   endfunction

   // ********
   // Scenarios.
   // ********
   task automatic t_token(input logic sof, input logic [7:0] pid);
      logic [15:0] lv;
      start(2'h0, pid, sof);
      grab(lv);
      chk_val(lv[7:0], `SBHPE_SYNC_BYTE);
      chk_val(pid_of(lv), sof ? `SBHPE_PID_SOF : pid);
      finish_xfer(`SBHPE_ST_OK);
   endtask

   task automatic t_hshake(input logic [7:0] g, input logic [1:0] m, input logic [3:0] exp);
      gap <= g;
      mode <= m;
      skip <= 2'h0;
      start(2'h1, 8'h69, 1'b0);
      finish_xfer(exp);
      mode <= 2'h0;
      @(posedge mclk);
   endtask

   task automatic t_out();
      int  n;
      logic r;
      n = 0;
      gap <= 8'h02;
      mode <= 2'h1;
      skip <= 2'h1;
      start(2'h2, 8'h69, 1'b0);
      @(posedge mclk);
      dma_tx_valid <= 1'b1;
      dma_tx_data <= 8'h10;
      for (int i = 0; i < 12; i++)
      begin
         @(negedge mclk);
         r = dma_tx_ready;
         @(posedge mclk);
         if (r)
         begin
            n++;
            dma_tx_data <= 8'h10 + 8'(n);
         end
      end
      dma_tx_valid <= 1'b0;
      chk_val(8'(n), 8'h04);
      finish_xfer(`SBHPE_ST_OK);
      mode <= 2'h0;
      @(posedge mclk);
   endtask

   task automatic t_in(input logic bad);
      logic [7:0] got [$];
      logic       v;
      logic [7:0] d;
      mode <= bad ? 2'h3 : 2'h2;
      skip <= 2'h0;
      start(2'h3, 8'hE1, 1'b0);
      finish_xfer(bad ? `SBHPE_ST_CRC_ERR : `SBHPE_ST_OK);
      mode <= 2'h0;
      @(posedge mclk);
      dma_rx_ready <= 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         @(negedge mclk);
         v = dma_rx_valid;
         d = dma_rx_data;
         @(posedge mclk);
         if (v)
            got.push_back(d);
      end
      dma_rx_ready <= 1'b0;
      if (!bad)
      begin
         // Both payload bytes and the two check code bytes pass through the FIFO.
         chk_val(8'(got.size()), 8'h04);
         chk_val(got[0], 8'h3C);
         chk_val(got[1], 8'hFE);
      end
      chk_flag(dma_rx_valid, 1'b0);
   endtask

   initial
   begin
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      repeat (2) @(posedge mclk);
      t_token(1'b0, 8'h69);
      t_token(1'b1, 8'h69);
      t_hshake(8'h02, 2'h1, `SBHPE_ST_OK);
      t_hshake(8'h1E, 2'h1, `SBHPE_ST_OK);
      t_hshake(8'h02, 2'h0, `SBHPE_ST_TIMEOUT);
      t_out();
      t_in(1'b0);
      t_in(1'b1);
      print_verdict();
   end

   // Whole run is near 3,000 cycles; this cuts a hang well beyond that.
   initial
   begin
      #400000;
      n_mismatch++;
      print_verdict();
   end
endmodule // sbhpe_engine_test
